/* rtl/robot_io_device.sv */
// controller end: sequences stop, resume, failure clear, skip and mode inputs
// assumes a PLC-like sequencer on the interface; inputs other than prog_num, INTERRUPT_REGION_I, CONT_PERMIT_I and FAIL_RESET_CLR_I pass 3-flop sync
// Operation
// [R1] step stop fall: finish step, halt, running off
// [R2] after step stop stay external, resume on start
// [R3] step stop off at start: single steps
// [R4] pendant allowed only after step stop fall
// [R5] instant stop fall: halt mid step, running off
// [R6] after instant stop keep mode, resume on start
// [R7] pendant allowed only after instant stop fall
// [R8] sequencer holds instant stop 50 ms minimum
// [R9] failure clear plus prep start leaves failure
// [R10] failure clear masks the four prep requests
// [R11] sequencer drops clear after failure output off
// [R12] sequencer raises clear 1 ms before prep
// [R13] skip during interruptible motion aborts current step
// [R14] sequencer keeps reset or start off on skip
// [R15] skip treats start as dropped, restart program
// [R16] continue start acts only in external mode
// [R17] continue start resumes halted program, ignores number
// [R18] continue without permission raises error code
// [R19] prep with all requests enters external auto
// [R20] start while step stopped resumes next step
// [R21] sequencer gives reset 1 ms before start
// [R22] inputs are levels, edges from synced samples
`timescale 1ns/1ns
`include "robot_io_consts.svh"
module robot_io_device
  import robot_io_pkg::*;
#(
  parameter int STEP_CYC = `STEP_CYC,
  parameter int PROG_STEPS = `PROG_STEPS
)
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  robot_io_if.device io,
  input wire logic FAULT_I,
  input wire logic INTERRUPT_REGION_I,
  input wire logic CONT_PERMIT_I,
  input wire logic FAIL_RESET_CLR_I,
  output logic PENDANT_OK_O,
  output logic [3:0] ACTIVE_PROG_O,
  output logic [3:0] STEP_O
);
  localparam int NIN = 10;
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] lvl;
    run_state_t st;
    logic [7:0] cnt;
    logic [3:0] step;
    logic [3:0] prog;
    logic halted;
    logic ext;
    logic run;
    logic fail;
    logic cyc_end;
    logic pend_ok;
    logic [15:0] err;
  } dev_state_t;
  dev_state_t q, d;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;
  logic [NIN-1:0] nlvl;
  logic start_rise;
  logic prep_ok;
  logic last_step;
  // input bit order
  localparam int I_SS = 0;
  localparam int I_IS = 1;
  localparam int I_FC = 2;
  localparam int I_PP = 3;
  localparam int I_SK = 4;
  localparam int I_CS = 5;
  localparam int I_ST = 6;
  localparam int I_RS = 7;
  localparam int I_RQ = 8;
  localparam int I_FL = 9;
  assign raw = {FAULT_I,
                io.motor_power_request & io.cal_request & io.full_speed_request &
                io.external_mode_request,
                io.prog_reset, io.prog_start, io.continue_start, io.interrupt_skip,
                io.prep_start, io.fail_clear, io.inst_stop_n, io.step_stop_n};
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // [R22] level changes once stages two and three agree
    nlvl = q.lvl;
    for (int i = 0; i < NIN; i++)
    begin
      if (q.s2[i] == q.s3[i])
        nlvl[i] = q.s3[i];
    end
    d.lvl = nlvl;
    rise = nlvl & ~q.lvl;
    fall = ~nlvl & q.lvl;
    last_step = (q.step == 4'(PROG_STEPS - 1));
    // [R15] skip makes start look dropped, so a held start re-arms
    start_rise = rise[I_ST] | (rise[I_SK] & nlvl[I_ST]);
    // [R10] failure clear masks the prep requests
    prep_ok = rise[I_PP] & nlvl[I_RQ] & ~nlvl[I_FC];
    d.cyc_end = 1'b0;
    // [R4] pendant only after step stop fall
    // [R7] or after instant stop fall
    if (fall[I_SS] || fall[I_IS])
      d.pend_ok = 1'b1;
    else if (rise[I_SS] && rise[I_IS])
      d.pend_ok = 1'b0;
    if (FAIL_RESET_CLR_I)
      d.err = 16'h0000;
    case (q.st)
      RUN_IDLE, RUN_HALT_STEP, RUN_HALT_NOW:
      begin
        if (start_rise && q.ext && nlvl[I_IS])
        begin
          // [R16] continue start only in external mode
          if (nlvl[I_CS] && q.ext)
          begin
            // [R18] continue without permission raises error
            if (!CONT_PERMIT_I)
              d.err = `ERR_CONT_NOT_PERMIT;
            // [R17] resume halted program, number ignored
            else if (q.halted)
            begin
              d.st = RUN_STEP;
              d.run = 1'b1;
              d.cnt = 8'h00;
            end
          end
          else if (q.halted && !nlvl[I_RS] && !rise[I_SK])
          begin
            // [R20] step stop resumes at next step
            // [R2] [R6] mode kept, program resumed
            if (q.st == RUN_HALT_STEP)
              d.step = last_step ? 4'h0 : q.step + 4'h1;
            d.st = RUN_STEP;
            d.run = 1'b1;
            d.cnt = 8'h00;
          end
          else
          begin
            d.prog = io.prog_num;
            d.step = 4'h0;
            d.st = RUN_STEP;
            d.run = 1'b1;
            d.cnt = 8'h00;
          end
          // a refused continue keeps the halted program for a later try
          if (d.st == RUN_STEP)
            d.halted = 1'b0;
        end
      end
      RUN_STEP:
      begin
        d.cnt = q.cnt + 8'h01;
        // [R5] instant stop halts mid step
        if (fall[I_IS])
        begin
          d.st = RUN_HALT_NOW;
          d.run = 1'b0;
          d.halted = 1'b1;
        end
        // [R13] skip aborts the step in an interrupt region
        else if (rise[I_SK] && INTERRUPT_REGION_I)
        begin
          d.cnt = 8'h00;
          d.step = last_step ? 4'h0 : q.step + 4'h1;
        end
        else if (q.cnt == 8'(STEP_CYC - 1))
        begin
          d.cnt = 8'h00;
          if (last_step)
          begin
            d.st = RUN_IDLE;
            d.run = 1'b0;
            d.step = 4'h0;
            d.cyc_end = 1'b1;
          end
          // [R1] [R3] step stop halts after the step ends
          else if (!nlvl[I_SS])
          begin
            d.st = RUN_HALT_STEP;
            d.run = 1'b0;
            d.halted = 1'b1;
          end
          else
            d.step = q.step + 4'h1;
        end
      end
      RUN_FAIL:
      begin
        d.ext = 1'b0;
        // [R9] clear plus prep leaves the failure state
        if (nlvl[I_FC] && rise[I_PP])
        begin
          d.fail = 1'b0;
          d.st = RUN_IDLE;
          d.halted = 1'b0;
        end
      end
      default:
        d.st = RUN_IDLE;
    endcase
    // a new failure wins over any step end or exit decided above
    if (rise[I_FL])
    begin
      d.fail = 1'b1;
      d.run = 1'b0;
      d.st = RUN_FAIL;
    end
    // [R19] prep with all requests enters external auto
    if (prep_ok && !d.fail)
      d.ext = 1'b1;
  end
  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      q <= '0;
      q.st <= RUN_IDLE;
    end
    else
      q <= d;
  end
  // outputs straight from flops
  assign io.robot_running = q.run;
  assign io.robot_failure = q.fail;
  assign io.external_mode = q.ext;
  assign io.cycle_end = q.cyc_end;
  assign io.error_code = q.err;
  assign PENDANT_OK_O = q.pend_ok;
  assign ACTIVE_PROG_O = q.prog;
  assign STEP_O = q.step;
endmodule

/* rtl/robot_io_consts.svh */
// constants of the robot system i/o sequencing link
// assumes a 10 MHz controller clock shared by both ends
`ifndef ROBOT_IO_CONSTS_SVH
`define ROBOT_IO_CONSTS_SVH
`define CLK_PERIOD_NS 100
// least instantaneous stop pulse, milliseconds
`define ISTOP_PULSE_MS 50
`define ISTOP_PULSE_CYC ((`ISTOP_PULSE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// least lead of clear/reset ahead of a start, milliseconds
`define LEAD_MS 1
`define LEAD_CYC ((`LEAD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// step length of the simulated motion, in cycles
`define STEP_CYC 16
// steps in one program cycle
`define PROG_STEPS 8
// continue-not-permitted error code
`define ERR_CONT_NOT_PERMIT 16'h27A8
`define CNT_W 20
`endif

/* rtl/robot_io_pkg.sv */
// types shared by both ends of the robot system i/o link
// assumes robot_io_consts.svh for all figures
package robot_io_pkg;
  typedef enum logic [2:0] {
    RUN_IDLE,
    RUN_STEP,
    RUN_HALT_STEP,
    RUN_HALT_NOW,
    RUN_FAIL
  } run_state_t;
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_CLEAR_LEAD,
    SEQ_PREP,
    SEQ_WAIT_EXT,
    SEQ_RUN,
    SEQ_WAIT_FAIL_OFF
  } seq_state_t;
endpackage

/* rtl/robot_io_if.sv */
// level signals between the external sequencer and the robot controller
// assumes both ends share one clock; no tristate wires
`timescale 1ns/1ns
interface robot_io_if;
  logic step_stop_n;
  logic inst_stop_n;
  logic fail_clear;
  logic prep_start;
  logic motor_power_request;
  logic cal_request;
  logic full_speed_request;
  logic external_mode_request;
  logic interrupt_skip;
  logic continue_start;
  logic prog_start;
  logic prog_reset;
  logic [3:0] prog_num;
  logic robot_running;
  logic robot_failure;
  logic external_mode;
  logic cycle_end;
  logic [15:0] error_code;
  modport device (
    input step_stop_n, inst_stop_n, fail_clear, prep_start, motor_power_request,
    input cal_request, full_speed_request, external_mode_request, interrupt_skip,
    input continue_start, prog_start, prog_reset, prog_num,
    output robot_running, robot_failure, external_mode, cycle_end, error_code
  );
  modport host (
    output step_stop_n, inst_stop_n, fail_clear, prep_start, motor_power_request,
    output cal_request, full_speed_request, external_mode_request, interrupt_skip,
    output continue_start, prog_start, prog_reset, prog_num,
    input robot_running, robot_failure, external_mode, cycle_end, error_code
  );
endinterface

/* rtl/robot_io_host.sv */
// sequencer end: mode entry, run, stops, failure clear, skip and continue
// assumes the controller end on the same clock; lead times in cycles
`timescale 1ns/1ns
`include "robot_io_consts.svh"
module robot_io_host
  import robot_io_pkg::*;
#(
  parameter int ISTOP_CYC = `ISTOP_PULSE_CYC,
  parameter int LEAD_CYC = `LEAD_CYC
)
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  robot_io_if.host io,
  input wire logic PREP_REQ_I,
  input wire logic RUN_REQ_I,
  input wire logic CLEAR_REQ_I,
  input wire logic STEP_STOP_REQ_I,
  input wire logic INST_STOP_REQ_I,
  input wire logic SKIP_REQ_I,
  input wire logic CONT_REQ_I,
  input wire logic RESTART_REQ_I,
  input wire logic [3:0] PROG_NUM_I,
  output logic BUSY_O
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    seq_state_t st;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] istop_cnt;
    logic ss_n;
    logic is_n;
    logic fc;
    logic pp;
    logic rq;
    logic sk;
    logic cs;
    logic ps;
    logic pr;
    logic [3:0] pn;
    logic busy;
  } host_state_t;
  host_state_t q, d;
  always_comb
  begin
    d = q;
    d.ss_n = ~STEP_STOP_REQ_I;
    d.cs = CONT_REQ_I;
    d.pn = PROG_NUM_I;
    // [R8] hold instant stop open at least the pulse width
    if (INST_STOP_REQ_I)
    begin
      d.is_n = 1'b0;
      d.istop_cnt = `CNT_W'(ISTOP_CYC);
    end
    else if (q.istop_cnt != '0)
      d.istop_cnt = q.istop_cnt - `CNT_W'(1);
    else
      d.is_n = 1'b1;
    // [R14] skip only while reset is off
    d.sk = SKIP_REQ_I & ~q.pr;
    case (q.st)
      SEQ_IDLE:
      begin
        d.pp = 1'b0;
        d.ps = 1'b0;
        d.cnt = '0;
        if (io.robot_failure && CLEAR_REQ_I)
        begin
          d.fc = 1'b1;
          d.st = SEQ_CLEAR_LEAD;
        end
        else if (PREP_REQ_I && !io.external_mode)
        begin
          d.rq = 1'b1;
          d.st = SEQ_PREP;
        end
        else if (RUN_REQ_I && io.external_mode)
        begin
          d.pr = RESTART_REQ_I;
          d.st = SEQ_RUN;
        end
      end
      // [R12] clear leads prep by the lead time
      SEQ_CLEAR_LEAD:
      begin
        d.cnt = q.cnt + `CNT_W'(1);
        if (q.cnt == `CNT_W'(LEAD_CYC))
        begin
          d.pp = 1'b1;
          // requests may ride along; the controller must ignore them
          d.rq = PREP_REQ_I;
          d.st = SEQ_WAIT_FAIL_OFF;
        end
      end
      // [R11] drop clear only after failure output off
      SEQ_WAIT_FAIL_OFF:
      begin
        if (!io.robot_failure)
        begin
          d.fc = 1'b0;
          d.pp = 1'b0;
          d.rq = 1'b0;
          d.st = SEQ_IDLE;
        end
      end
      SEQ_PREP:
      begin
        d.pp = 1'b1;
        d.st = SEQ_WAIT_EXT;
      end
      SEQ_WAIT_EXT:
      begin
        if (io.external_mode)
        begin
          d.pp = 1'b0;
          d.rq = 1'b0;
          d.st = SEQ_IDLE;
        end
      end
      // [R21] reset leads start by the lead time
      SEQ_RUN:
      begin
        d.cnt = q.cnt + `CNT_W'(1);
        if (q.cnt == `CNT_W'(LEAD_CYC))
          d.ps = 1'b1;
        if (q.ps && io.robot_running)
        begin
          d.pr = 1'b0;
          d.ps = 1'b0;
          d.st = SEQ_IDLE;
        end
        // a refused start never runs, so a withdrawn request ends the wait
        else if (!RUN_REQ_I)
        begin
          d.pr = 1'b0;
          d.ps = 1'b0;
          d.st = SEQ_IDLE;
        end
      end
      default:
        d.st = SEQ_IDLE;
    endcase
    d.busy = (d.st != SEQ_IDLE);
  end
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      q <= '0;
      q.st <= SEQ_IDLE;
      q.ss_n <= 1'b1;
      q.is_n <= 1'b1;
    end
    else
      q <= d;
  end
  assign io.step_stop_n = q.ss_n;
  assign io.inst_stop_n = q.is_n;
  assign io.fail_clear = q.fc;
  assign io.prep_start = q.pp;
  assign io.motor_power_request = q.rq;
  assign io.cal_request = q.rq;
  assign io.full_speed_request = q.rq;
  assign io.external_mode_request = q.rq;
  assign io.interrupt_skip = q.sk;
  assign io.continue_start = q.cs;
  assign io.prog_start = q.ps;
  assign io.prog_reset = q.pr;
  assign io.prog_num = q.pn;
  assign BUSY_O = q.busy;
endmodule

/* dv/robot_io_checker.sv */
// checker of the robot i/o link, watching the interface levels only
// assumes one clock, async active-low reset and the bench's short counts
`timescale 1ns/1ns
`include "robot_io_consts.svh"
module robot_io_checker
#(
  parameter int ISTOP_CYC = 20,
  parameter int LEAD_CYC = 4
)
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic step_stop_n,
  input wire logic inst_stop_n,
  input wire logic fail_clear,
  input wire logic prep_start,
  input wire logic interrupt_skip,
  input wire logic prog_start,
  input wire logic prog_reset,
  input wire logic robot_running,
  input wire logic robot_failure,
  input wire logic external_mode,
  input wire logic cycle_end,
  input wire logic [15:0] error_code
);
  // ****************************************
  // helper logic and properties
  // ****************************************
  logic [7:0] low_cnt_q;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // length of the current stop pulse; saturates so long holds never wrap
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      low_cnt_q <= 8'h00;
    else if (inst_stop_n)
      low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF)
      low_cnt_q <= low_cnt_q + 8'h01;
  end
  sequence s_istop_fall;
    $fell(inst_stop_n);
  endsequence
  sequence s_clear_held;
    fail_clear [*8];
  endsequence
  // sync delay plus one whole step at most
  a_step_stop_halt: assert property ($fell(step_stop_n) && robot_running |-> ##[1:24] !robot_running)
    else $error("running stayed on after step stop");
  a_istop_halt: assert property (s_istop_fall |-> ##[1:8] !robot_running)
    else $error("running stayed on after instant stop");
  a_istop_width: assert property ($rose(inst_stop_n) |-> low_cnt_q >= ISTOP_CYC)
    else $error("instant stop pulse too short");
  a_run_needs_ext: assert property ($rose(robot_running) |-> external_mode)
    else $error("running began outside external mode");
  a_prep_masked: assert property (s_clear_held |-> !$rose(external_mode))
    else $error("external mode entered while failure clear held");
  a_fail_exit: assert property ($fell(robot_failure) |-> fail_clear)
    else $error("failure left without clear");
  a_clear_drop: assert property ($fell(fail_clear) |-> !robot_failure)
    else $error("clear dropped before failure output off");
  a_clear_lead: assert property ($rose(prep_start) && fail_clear |-> $past(fail_clear, LEAD_CYC))
    else $error("clear not raised ahead of prep start");
  a_skip_start_off: assert property ($rose(interrupt_skip) |-> !(prog_reset && prog_start))
    else $error("skip raised with reset and start both on");
  a_err_code: assert property (error_code != 16'h0000 |-> error_code == `ERR_CONT_NOT_PERMIT)
    else $error("unexpected error code");
  a_cycle_end_idle: assert property (cycle_end |-> !robot_running)
    else $error("running still on at cycle end");
endmodule

/* dv/robot_stop_resume_inputs_tb.sv */
// bench of the robot i/o link: host and device ends joined by one interface
// assumes short lead and pulse counts; random program numbers from seed 70
`timescale 1ns/1ns
module robot_stop_resume_inputs_tb;
  // ****************************************
  // stimulus, instances and checks
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prep, run, clr, sstop, istop, skip, cont, rst_req, fault, region, permit, err_clr;
  logic [3:0] pnum, act_prog, step, keep;
  logic pend_ok, busy;
  int err_total = 0;
  int check_count = 0;
  robot_io_if io ();
  always #50 clk = ~clk;
  robot_io_device u_robot_io_device (.REF_CLK_I(clk), .ARST_N_I(rst_n), .io(io),
    .FAULT_I(fault), .INTERRUPT_REGION_I(region), .CONT_PERMIT_I(permit),
    .FAIL_RESET_CLR_I(err_clr), .PENDANT_OK_O(pend_ok), .ACTIVE_PROG_O(act_prog),
    .STEP_O(step));
  robot_io_host #(.ISTOP_CYC(20), .LEAD_CYC(4)) u_robot_io_host (.REF_CLK_I(clk),
    .ARST_N_I(rst_n), .io(io), .PREP_REQ_I(prep), .RUN_REQ_I(run), .CLEAR_REQ_I(clr),
    .STEP_STOP_REQ_I(sstop), .INST_STOP_REQ_I(istop), .SKIP_REQ_I(skip),
    .CONT_REQ_I(cont), .RESTART_REQ_I(rst_req), .PROG_NUM_I(pnum), .BUSY_O(busy));
  robot_io_checker #(.ISTOP_CYC(20), .LEAD_CYC(4)) u_robot_io_checker (.REF_CLK_I(clk),
    .ARST_N_I(rst_n), .step_stop_n(io.step_stop_n), .inst_stop_n(io.inst_stop_n),
    .fail_clear(io.fail_clear), .prep_start(io.prep_start),
    .interrupt_skip(io.interrupt_skip), .prog_start(io.prog_start),
    .prog_reset(io.prog_reset), .robot_running(io.robot_running),
    .robot_failure(io.robot_failure), .external_mode(io.external_mode),
    .cycle_end(io.cycle_end),
    .error_code(io.error_code));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait on running (0), external mode (1) or failure (2)
  task automatic wait_for(input int sel, input logic val, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? io.robot_running : (sel == 1) ? io.external_mode : io.robot_failure;
      if (s === val)
        return;
    end
    err_total++;
    $display("mismatch wait %0d expected %b seen timeout", sel, val);
  endtask
  // start is held until running shows, then dropped as a sequencer would
  task automatic start;
    @(posedge clk);
    run <= 1'b1;
    wait_for(0, 1'b1, 100);
    @(posedge clk);
    run <= 1'b0;
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog, far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial
  begin
    {prep, run, clr, sstop, istop, skip, cont, rst_req, fault, region, permit, err_clr} = '0;
    pnum = 4'h0;
    void'($urandom(70));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    prep <= 1'b1;
    wait_for(1, 1'b1, 200);
    check("ext_mode", io.external_mode, 1'b1);
    @(posedge clk);
    prep <= 1'b0;
    // random programs from the first step, each cut by a step stop
    for (int n = 0; n < 3; n++)
    begin
      @(posedge clk);
      pnum <= 4'($urandom_range(15));
      rst_req <= 1'b1;
      start();
      rst_req <= 1'b0;
      check("prog", act_prog, pnum);
      keep = act_prog;
      @(posedge clk);
      sstop <= 1'b1;
      wait_for(0, 1'b0, 40);
      check("ext_step", io.external_mode, 1'b1);
      check("pendant", pend_ok, 1'b1);
      @(posedge clk);
      sstop <= 1'b0;
    end
    // continue without permission only raises the error code
    @(posedge clk);
    cont <= 1'b1;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("err", io.error_code, 16'h27A8);
    check("busy", busy, 1'b1);
    run <= 1'b0;
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    permit <= 1'b1;
    pnum <= keep + 4'h1;
    repeat (2) @(posedge clk);
    #1;
    check("err_clr", io.error_code, 16'h0000);
    start();
    check("cont_prog", act_prog, keep);
    cont <= 1'b0;
    // instant stop mid step, then resume
    @(posedge clk);
    istop <= 1'b1;
    wait_for(0, 1'b0, 10);
    check("ext_istop", io.external_mode, 1'b1);
    repeat (30) @(posedge clk);
    istop <= 1'b0;
    region <= 1'b1;
    repeat (30) @(posedge clk);
    start();
    check("istop_prog", act_prog, keep);
    // skip right after a step begins must advance well before the step ends
    keep = step;
    @(posedge clk);
    skip <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check("skip", step != keep, 1'b1);
    skip <= 1'b0;
    region <= 1'b0;
    // the program then runs out to its cycle end and stops there
    wait_for(0, 1'b0, 200);
    check("cycle_end_step", step, 4'h0);
    start();
    // failure, then clear; the prep requests stay masked
    @(posedge clk);
    fault <= 1'b1;
    wait_for(2, 1'b1, 20);
    fault <= 1'b0;
    check("fail_run", io.robot_running, 1'b0);
    @(posedge clk);
    clr <= 1'b1;
    // requests shown alongside the clear must be ignored
    prep <= 1'b1;
    wait_for(2, 1'b0, 100);
    check("fail_off", io.robot_failure, 1'b0);
    check("ext_masked", io.external_mode, 1'b0);
    clr <= 1'b0;
    prep <= 1'b0;
    repeat (10) @(posedge clk);
    conclude();
  end
endmodule
